// >>> verilog/fcp_pkg.sv
/*
  constants for the post-parse classify and police stage:
  register offsets, field positions, write masks, reset values, timing.
  assumes a 40 MHz core clock and a 32-bit apb register bus.
*/
`default_nettype none
package fcp_pkg;
  // timing
  localparam int CLK_NS   = 25;
  localparam int TICK_NS  = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // result widths
  localparam int FQ_W   = 24;
  localparam int SP_W   = 5;
  localparam int PORT_W = 4;
  localparam int RES_W  = FQ_W + SP_W + PORT_W + 3;
  // register byte offsets
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STAT    = 8'h04;
  localparam logic [7:0] A_FRAMES  = 8'h08;
  localparam logic [7:0] A_RED     = 8'h0C;
  localparam logic [7:0] A_SETSEL  = 8'h10;
  localparam logic [7:0] A_SETCFG  = 8'h14;
  localparam logic [7:0] A_SETBASE = 8'h18;
  localparam logic [7:0] A_SETHMSK = 8'h1C;
  localparam logic [7:0] A_ENTSEL  = 8'h20;
  localparam logic [7:0] A_ENTKEY  = 8'h24;
  localparam logic [7:0] A_ENTACT  = 8'h28;
  localparam logic [7:0] A_ENTFQ   = 8'h2C;
  localparam logic [7:0] A_PRFSEL  = 8'h30;
  localparam logic [7:0] A_RATES   = 8'h34;
  localparam logic [7:0] A_BURST   = 8'h38;
  localparam logic [7:0] A_PRFCFG  = 8'h3C;
  localparam logic [7:0] A_OFFL    = 8'h40;
  // set config fields
  localparam int SC_LOOK   = 0;
  localparam int SC_FIRST  = 1;
  localparam int SC_SP     = 5;
  localparam int SC_SHIFT  = 10;
  localparam int SC_IDX    = 16;
  localparam int SC_SPREAD = 24;
  // entry key and action fields
  localparam int EK_INFO  = 16;
  localparam int EA_CHAIN = 0;
  localparam int EA_NEXT  = 1;
  localparam int EA_HASH  = 5;
  localparam int EA_POL   = 6;
  localparam int EA_PRF   = 8;
  localparam int EA_SP    = 16;
  // profile config fields
  localparam int PC_4115 = 0;
  localparam int PC_DROP = 1;
  // write masks, unused bits read as zero
  localparam logic [31:0] M_CTRL   = 32'h0000_0001;
  localparam logic [31:0] M_SETCFG = 32'hFFFF_3FFF;
  localparam logic [31:0] M_ENTKEY = 32'h00FF_FFFF;
  localparam logic [31:0] M_ENTACT = 32'h001F_FF7F;
  localparam logic [31:0] M_PRFCFG = 32'h0000_0003;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // colors
  localparam logic [1:0] C_GREEN  = 2'h0;
  localparam logic [1:0] C_YELLOW = 2'h1;
  localparam logic [1:0] C_RED    = 2'h2;
  typedef enum logic [2:0] {S_IDLE, S_LOOK, S_HASH, S_POLICE, S_PUSH} state_e;
endpackage
`default_nettype wire

// >>> verilog/fifo_if.sv
/*
  push and pop handshakes of the result fifo.
  assumes one clock shared by both sides.
*/
`default_nettype none
interface fifo_if #(parameter int W = 8);
  logic         pushValid;
  logic         pushReady;
  logic [W-1:0] pushData;
  logic         popValid;
  logic         popReady;
  logic [W-1:0] popData;
  modport fifo (input pushValid, pushData, popReady, output pushReady, popValid, popData);
  modport user (output pushValid, pushData, popReady, input pushReady, popValid, popData);
endinterface
`default_nettype wire

// >>> verilog/stream_fifo.sv
/*
  flop-based fifo with a registered output stage.
  assumes push and pop on the same clock, synchronous active-high reset.
*/
`default_nettype none
module stream_fifo
  import fcp_pkg::*;
#(
  parameter int W     = 8,
  parameter int DEPTH = 16
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // both handshakes
  fifo_if.fifo     q
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(q.pushData) != W)
    $error("stream_fifo: DEPTH must be a power of two and W must match");

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0]   count_r;
  logic          pushOk;
  logic          load;

  assign q.pushReady = (count_r != (AW+1)'(DEPTH));
  assign pushOk      = q.pushValid && q.pushReady;
  // refill the output stage when it is empty or being drained
  assign load        = (count_r != '0) && (!q.popValid || q.popReady);

  always_ff @(posedge clk)
  begin
    if (pushOk)
      mem[wrPtr_r] <= q.pushData;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (pushOk)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (load)
        rdPtr_r <= rdPtr_r + 1'b1;
      count_r <= count_r + (AW+1)'(pushOk) - (AW+1)'(load);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q.popValid <= 1'b0;
      q.popData  <= '0;
    end
    else if (load)
    begin
      q.popValid <= 1'b1;
      q.popData  <= mem[rdPtr_r];
    end
    else if (q.popReady)
      q.popValid <= 1'b0;
  end
endmodule
`default_nettype wire

// >>> verilog/frame_classify_police.sv
/*
  post-parse stage: picks hash spreading or chained table lookup per frame,
  forms the frame_queue_id and storage profile, and polices with trtcm.
  assumes a parser upstream with valid/ready and a queue manager downstream
  that discards frames marked drop; registers reached over apb.
*/
// Implementation choices: the APB register port and the address map.
`default_nettype none
// What this block does
// R01 - each parsed frame starts on one path, hash spreading or table lookup; lookups that miss or yield a hash key go on to hashing.
// R02 - hash path folds masked frame fields into a frame_queue_id offset from a base.
// R03 - hashed queue id is further offset by masked, shifted type-of-service bits.
// R04 - software fills lookup sets; parser's set number picks which set runs.
// R05 - a hit may chain: its key info builds the next lookup's key.
// R06 - finished lookups yield either a hash key or a direct frame_queue_id.
// R07 - lookup result says whether to police and with which profile.
// R08 - up to 256 profiles; red traffic is dropped or marked per profile.
// R09 - each profile runs basic or differentiated-service two-rate three-color marking.
// R10 - software sets committed rate, peak rate and burst sizes per profile.
// R11 - frames flagged as internally originated are classified the same way.
// R12 - storage profile is chosen with the queue id, after classification.
// R13 - 32 storage profiles per port, sent downstream alongside the port.
// R14 - buckets refill by rate over time, length sets color, buckets debited.
module frame_classify_police
  import fcp_pkg::*;
#(
  parameter int NSET  = 8,
  parameter int NENT  = 16,
  parameter int NPROF = 256,
  parameter int FDEP  = 16
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // parsed frame in
  input  wire logic              inValid,
  output logic                   inReady,
  input  wire logic [PORT_W-1:0] inPort,
  input  wire logic [2:0]        inSet,
  input  wire logic              inOffline,
  input  wire logic [31:0]       inHashFields,
  input  wire logic [15:0]       inLookupKey,
  input  wire logic [7:0]        inTos,
  input  wire logic [15:0]       inLen,
  // result out
  output logic                   outValid,
  input  wire logic              outReady,
  output logic [FQ_W-1:0]        outFqid,
  output logic [SP_W-1:0]        outStorage,
  output logic [PORT_W-1:0]      outPort,
  output logic [1:0]             outColor,
  output logic                   outDrop
);
  localparam int SW = $clog2(NSET);
  localparam int EW = $clog2(NENT);
  localparam int PW = $clog2(NPROF);

  if (NSET < 2 || NSET > 8 || (1 << SW) != NSET || NENT < 2 || NENT > 16 || (1 << EW) != NENT
      || NPROF < 2 || NPROF > 256 || (1 << PW) != NPROF)
    $error("frame_classify_police: table sizes must be powers of two within field widths");

  function automatic logic [7:0] fold8(input logic [31:0] v);
    fold8 = v[7:0] ^ {v[14:8], v[15]} ^ v[23:16] ^ {v[28:24], v[31:29]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state so the answer comes from flops

  logic [31:0] ctrl_r;
  logic [SW-1:0] setSel_r;
  logic [EW-1:0] entSel_r;
  logic [PW-1:0] prfSel_r;
  logic [31:0] setCfg_r  [NSET];
  logic [FQ_W-1:0] setBase_r [NSET];
  logic [31:0] setHmsk_r [NSET];
  logic [31:0] entKey_r  [NENT];
  logic [31:0] entAct_r  [NENT];
  logic [FQ_W-1:0] entFq_r [NENT];
  logic [31:0] rates_r   [NPROF];
  logic [31:0] burst_r   [NPROF];
  logic [1:0]  prfCfg_r  [NPROF];
  logic [31:0] frames_r;
  logic [31:0] red_r;
  logic [31:0] offl_r;
  logic        pready_r;
  logic [31:0] rdData;
  logic        rdHit;
  logic        wrFire;
  state_e      state_r;
  fifo_if #(.W(RES_W)) q ();

  assign wrFire = psel && penable && pready_r && pwrite && paddr[11:8] == 4'h0;

  always_comb
  begin
    rdData = '0;
    rdHit  = (paddr[11:8] == 4'h0);
    case (paddr[7:0])
      A_CTRL:    rdData = ctrl_r;
      A_STAT:    rdData = {29'h0000_0000, inReady, !q.pushReady, state_r != S_IDLE};
      A_FRAMES:  rdData = frames_r;
      A_RED:     rdData = red_r;
      A_OFFL:    rdData = offl_r;
      A_SETSEL:  rdData = 32'(setSel_r);
      A_SETCFG:  rdData = setCfg_r[setSel_r];
      A_SETBASE: rdData = 32'(setBase_r[setSel_r]);
      A_SETHMSK: rdData = setHmsk_r[setSel_r];
      A_ENTSEL:  rdData = 32'(entSel_r);
      A_ENTKEY:  rdData = entKey_r[entSel_r];
      A_ENTACT:  rdData = entAct_r[entSel_r];
      A_ENTFQ:   rdData = 32'(entFq_r[entSel_r]);
      A_PRFSEL:  rdData = 32'(prfSel_r);
      A_RATES:   rdData = rates_r[prfSel_r];
      A_BURST:   rdData = burst_r[prfSel_r];
      A_PRFCFG:  rdData = 32'(prfCfg_r[prfSel_r]);
      default:   rdHit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready_r <= 1'b0;
      prdata   <= '0;
      pslverr  <= 1'b0;
    end
    else
    begin
      pready_r <= psel && penable && !pready_r;
      if (psel && penable && !pready_r)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : rdData;
        pslverr <= !rdHit;
      end
    end
  end
  assign pready = pready_r;

  // selectors and control
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_r   <= CTRL_RST;
      setSel_r <= '0;
      entSel_r <= '0;
      prfSel_r <= '0;
    end
    else if (wrFire)
    begin
      case (paddr[7:0])
        A_CTRL:   ctrl_r   <= pwdata & M_CTRL;
        A_SETSEL: setSel_r <= pwdata[SW-1:0];
        A_ENTSEL: entSel_r <= pwdata[EW-1:0];
        A_PRFSEL: prfSel_r <= pwdata[PW-1:0];
        default:  ;
      endcase
    end
  end

  // lookup sets and entries
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NSET; i++)
      begin
        setCfg_r[i]  <= '0;
        setBase_r[i] <= '0;
        setHmsk_r[i] <= '1;
      end
      for (int i = 0; i < NENT; i++)
      begin
        entKey_r[i] <= '0;
        entAct_r[i] <= '0;
        entFq_r[i]  <= '0;
      end
    end
    else if (wrFire)
    begin
      case (paddr[7:0])
        A_SETCFG:  setCfg_r[setSel_r]  <= pwdata & M_SETCFG; // R04
        A_SETBASE: setBase_r[setSel_r] <= pwdata[FQ_W-1:0];
        A_SETHMSK: setHmsk_r[setSel_r] <= pwdata;
        A_ENTKEY:  entKey_r[entSel_r]  <= pwdata & M_ENTKEY;
        A_ENTACT:  entAct_r[entSel_r]  <= pwdata & M_ENTACT;
        A_ENTFQ:   entFq_r[entSel_r]   <= pwdata[FQ_W-1:0];
        default:   ;
      endcase
    end
  end

  // policing profiles
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NPROF; i++)
      begin
        rates_r[i]  <= '0;
        burst_r[i]  <= '0;
        prfCfg_r[i] <= '0;
      end
    end
    else if (wrFire)
    begin
      case (paddr[7:0])
        A_RATES:  rates_r[prfSel_r]  <= pwdata; // R10
        A_BURST:  burst_r[prfSel_r]  <= pwdata; // R10
        A_PRFCFG: prfCfg_r[prfSel_r] <= 2'(pwdata & M_PRFCFG);
        default:  ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer

  logic [SW-1:0]     set_r;
  logic [PORT_W-1:0] port_r;
  logic              offl_f;
  logic [31:0]       hashKey_r;
  logic [15:0]       curKey_r;
  logic [7:0]        tos_r;
  logic [15:0]       len_r;
  logic [EW-1:0]     entIdx_r;
  logic [EW-1:0]     steps_r;
  logic [FQ_W-1:0]   frame_queue_id_r;
  logic [SP_W-1:0]   sp_r;
  logic              police_r;
  logic [PW-1:0]     prf_r;
  logic [1:0]        color_r;
  logic              drop_r;
  logic              accept;
  logic              hit;
  logic [31:0]       act;
  logic [31:0]       cfg;
  logic [FQ_W-1:0]   hashFq;

  assign accept = inValid && inReady;
  assign act    = entAct_r[entIdx_r];
  assign cfg    = setCfg_r[set_r];
  assign hit    = entKey_r[entIdx_r][15:0] == curKey_r;
  // R02 R03
  assign hashFq = setBase_r[set_r]
                + FQ_W'(fold8(hashKey_r) & cfg[SC_SPREAD +: 8])
                + FQ_W'({16'h0000, tos_r & cfg[SC_IDX +: 8]} << cfg[SC_SHIFT +: 4]);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= S_IDLE;
      inReady <= 1'b0;
    end
    else
    begin
      inReady <= ctrl_r[0] && ((state_r == S_IDLE && !accept) || (state_r == S_PUSH && q.pushReady));
      case (state_r)
        S_IDLE:
          if (accept)
            state_r <= setCfg_r[inSet[SW-1:0]][SC_LOOK] ? S_LOOK : S_HASH; // R01 R04 R11
        S_LOOK:
          if (hit && act[EA_CHAIN] && steps_r != EW'(NENT - 1))
            state_r <= S_LOOK; // R05
          else if (hit && !act[EA_HASH])
            state_r <= act[EA_POL] ? S_POLICE : S_PUSH; // R06 R07
          else
            state_r <= S_HASH;
        S_HASH:
          state_r <= police_r ? S_POLICE : S_PUSH;
        S_POLICE:
          state_r <= S_PUSH;
        S_PUSH:
          if (q.pushReady)
            state_r <= S_IDLE;
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      set_r     <= '0;
      port_r    <= '0;
      offl_f    <= 1'b0;
      hashKey_r <= '0;
      curKey_r  <= '0;
      tos_r     <= '0;
      len_r     <= '0;
      entIdx_r  <= '0;
      steps_r   <= '0;
      frame_queue_id_r    <= '0;
      sp_r      <= '0;
      police_r  <= 1'b0;
      prf_r     <= '0;
    end
    else if (state_r == S_IDLE && accept)
    begin
      set_r     <= inSet[SW-1:0];
      port_r    <= inPort;
      offl_f    <= inOffline;
      hashKey_r <= inHashFields & setHmsk_r[inSet[SW-1:0]]; // R02
      curKey_r  <= inLookupKey;
      tos_r     <= inTos;
      len_r     <= inLen;
      entIdx_r  <= setCfg_r[inSet[SW-1:0]][SC_FIRST +: EW]; // R04
      steps_r   <= '0;
      sp_r      <= setCfg_r[inSet[SW-1:0]][SC_SP +: SP_W];
      police_r  <= 1'b0;
      prf_r     <= '0;
    end
    else if (state_r == S_LOOK && hit)
    begin
      sp_r     <= act[EA_SP +: SP_W]; // R12 R13
      police_r <= act[EA_POL]; // R07
      prf_r    <= act[EA_PRF +: PW]; // R07 R08
      if (act[EA_CHAIN] && steps_r != EW'(NENT - 1))
      begin
        curKey_r <= {entKey_r[entIdx_r][EK_INFO +: 8], curKey_r[7:0]}; // R05
        entIdx_r <= act[EA_NEXT +: EW];
        steps_r  <= steps_r + 1'b1;
      end
      else if (act[EA_HASH])
        hashKey_r <= hashKey_r ^ 32'(entFq_r[entIdx_r]); // R06
      else
        frame_queue_id_r <= entFq_r[entIdx_r]; // R06
    end
    else if (state_r == S_HASH)
      frame_queue_id_r <= hashFq; // R02 R03
  end

  ////////////////////////////////////////////////////////////////////////////
  // policer: lazy refill from a shared time tick

  logic [15:0] tc_r   [NPROF];
  logic [15:0] tp_r   [NPROF];
  logic [15:0] last_r [NPROF];
  logic [15:0] tick_r;
  logic [$clog2(TICK_CYC)-1:0] div_r;
  logic [15:0] delta;
  logic [32:0] sumC;
  logic [32:0] sumP;
  logic [15:0] tcF;
  logic [15:0] tpF;
  logic [15:0] tcN;
  logic [15:0] tpN;
  logic [1:0]  colorN;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_r  <= '0;
      tick_r <= '0;
    end
    else if (div_r == ($clog2(TICK_CYC))'(TICK_CYC - 1))
    begin
      div_r  <= '0;
      tick_r <= tick_r + 1'b1;
    end
    else
      div_r <= div_r + 1'b1;
  end

  // idle gaps over 65535 ticks alias; buckets are then refilled short
  always_comb
  begin
    delta  = tick_r - last_r[prf_r];
    sumC   = 33'(tc_r[prf_r]) + 33'(rates_r[prf_r][15:0]) * 33'(delta); // R14
    sumP   = 33'(tp_r[prf_r]) + 33'(rates_r[prf_r][31:16]) * 33'(delta); // R14
    tcF    = (sumC > 33'(burst_r[prf_r][15:0])) ? burst_r[prf_r][15:0] : sumC[15:0];
    tpF    = (sumP > 33'(burst_r[prf_r][31:16])) ? burst_r[prf_r][31:16] : sumP[15:0];
    tcN    = tcF;
    tpN    = tpF;
    colorN = C_RED;
    if (prfCfg_r[prf_r][PC_4115]) // R09
    begin
      if (tcF >= len_r)
      begin
        colorN = C_GREEN;
        tcN    = tcF - len_r;
      end
      else if (tpF >= len_r)
      begin
        colorN = C_YELLOW;
        tpN    = tpF - len_r;
      end
    end
    else if (tpF >= len_r) // R09
    begin
      tpN = tpF - len_r;
      if (tcF >= len_r)
      begin
        colorN = C_GREEN;
        tcN    = tcF - len_r;
      end
      else
        colorN = C_YELLOW;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NPROF; i++)
      begin
        tc_r[i]   <= '0;
        tp_r[i]   <= '0;
        last_r[i] <= '0;
      end
    end
    else if (state_r == S_POLICE)
    begin
      tc_r[prf_r]   <= tcN; // R14
      tp_r[prf_r]   <= tpN; // R14
      last_r[prf_r] <= tick_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || state_r == S_IDLE)
    begin
      color_r <= C_GREEN;
      drop_r  <= 1'b0;
    end
    else if (state_r == S_POLICE)
    begin
      color_r <= colorN; // R08
      drop_r  <= colorN == C_RED && prfCfg_r[prf_r][PC_DROP]; // R08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters and result fifo

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frames_r <= '0;
      red_r    <= '0;
      offl_r   <= '0;
    end
    else if (state_r == S_PUSH && q.pushReady)
    begin
      frames_r <= frames_r + 1'b1;
      red_r    <= red_r + 32'(color_r == C_RED);
      offl_r   <= offl_r + 32'(offl_f); // R11
    end
  end

  assign q.pushValid = (state_r == S_PUSH);
  assign q.pushData  = {frame_queue_id_r, sp_r, port_r, color_r, drop_r}; // R12 R13
  assign q.popReady  = outReady;

  stream_fifo #(.W(RES_W), .DEPTH(FDEP)) u_fifo (
    .clk (clk),
    .rst (rst),
    .q   (q)
  );

  assign outValid = q.popValid;
  assign {outFqid, outStorage, outPort, outColor, outDrop} = q.popData;
endmodule
`default_nettype wire

// >>> dv/fcp_properties.sv
/*
  port-level checks of the classify and police stage.
  assumes one clock and the apb and frame handshakes.
*/
`default_nettype none
module fcp_properties
  import fcp_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // apb
  input wire logic [11:0]       paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // frame stream
  input wire logic              inValid,
  input wire logic              inReady,
  input wire logic              outValid,
  input wire logic              outReady,
  input wire logic [FQ_W-1:0]   outFqid,
  input wire logic [SP_W-1:0]   outStorage,
  input wire logic [1:0]        outColor,
  input wire logic              outDrop
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  chk_ready_pulse: assert property (pready |=> !pready) else $error("long pready");
  chk_ready_after: assert property (psel && penable && !pready |=> pready) else $error("no apb answer");
  chk_unmapped_err: assert property (pready && paddr[11:8] != 4'h0 |-> pslverr) else $error("no error");
  chk_mapped_ok: assert property (pready && paddr[11:8] == 4'h0
    |-> !pslverr && (!pwrite || prdata == 32'h0000_0000)) else $error("bad mapped answer");
  chk_one_frame: assert property (inValid && inReady |=> !inReady) else $error("second frame taken");
  chk_result_hold: assert property (outValid && !outReady |=> outValid && $stable(outFqid)
    && $stable(outStorage) && $stable(outColor)) else $error("result moved");
  chk_drop_red: assert property (outValid && outDrop |-> outColor == C_RED) else $error("drop not red");
  chk_color_legal: assert property (outValid |-> outColor != 2'h3) else $error("illegal color");
endmodule
bind frame_classify_police fcp_properties chk (.*);
`default_nettype wire

// >>> dv/qm_sink_model.sv
/*
  downstream stand-in: takes results, stalls or paces them.
  assumes hold and slow change between frames.
*/
`default_nettype none
module qm_sink_model
  import fcp_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // pacing
  input wire logic              hold,
  input wire logic              slow,
  // result stream
  input wire logic              outValid,
  output logic                  outReady,
  input wire logic [FQ_W-1:0]   outFqid,
  input wire logic [SP_W-1:0]   outStorage,
  input wire logic [PORT_W-1:0] outPort,
  input wire logic [1:0]        outColor,
  input wire logic              outDrop,
  // last result and count
  output logic [RES_W-1:0]      lastRes,
  output logic [15:0]           gotCnt
);
  logic phase_r;
  // slow mode accepts every other cycle, so the block must hold results
  assign outReady = !hold && (!slow || phase_r);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_r <= 1'b0;
      gotCnt <= 16'h0000;
      lastRes <= '0;
    end
    else
    begin
      phase_r <= !phase_r;
      if (outValid && outReady)
      begin
        lastRes <= {outDrop, outColor, outPort, outStorage, outFqid};
        gotCnt <= gotCnt + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
/*
  self-checking bench of the classify and police stage.
  assumes the sink model downstream; bench is parser and apb master.
*/
`default_nettype none
module tb
  import fcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] set; logic [7:0] tos; logic [7:0] msk; logic [3:0] sh;
    logic [23:0] base; logic [4:0] sp; logic off;} row_s;
  logic              clk, rst, psel, penable, pwrite, pready, pslverr, hold, slow;
  logic              inValid, inReady, inOffline, outValid, outReady, outDrop;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rdat, inHashFields;
  logic [2:0]        inSet;
  logic [PORT_W-1:0] inPort, outPort;
  logic [15:0]       inLookupKey, inLen, gotCnt;
  logic [7:0]        inTos;
  logic [FQ_W-1:0]   outFqid;
  logic [SP_W-1:0]   outStorage;
  logic [1:0]        outColor;
  logic [RES_W-1:0]  lastRes;
  logic              rerr;
  int                nFail, samplesChecked, nSent;
  localparam logic [32:0] hitRes = {4'hD, 5'd9, 24'h00_5555};
  row_s rows [4] = '{'{3'd1, 8'hB5, 8'h0F, 4'h0, 24'h00_0100, 5'd3, 1'b0},
    '{3'd2, 8'hFF, 8'hE0, 4'h4, 24'hFF_FF00, 5'd31, 1'b0}, '{3'd3, 8'h5A, 8'h00, 4'h2, 24'h00_0042, 5'd0, 1'b1},
    '{3'd7, 8'h01, 8'h01, 4'hF, 24'h00_0000, 5'd17, 1'b0}};
  frame_classify_police uut (.*);
  qm_sink_model sink (.*);
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hang;
    nFail++;
    $display("BAD %0t wait ran out", $time);
    endOfTest;
  endtask
  task automatic chk(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nFail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // request held until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    @(negedge clk);
    while (pready !== 1'b1)
    begin
      @(negedge clk);
      k++;
      if (k > 50) hang;
    end
    @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk({4'h0, rdat}, {4'h0, exp});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic send(input logic [2:0] s, input logic off, input logic [15:0] key, input logic [7:0] tos);
    int k;
    @(posedge clk);
    inValid <= 1'b1;
    inSet <= s;
    inPort <= {1'b1, s};
    inOffline <= off;
    inLookupKey <= key;
    inHashFields <= {key, key};
    inTos <= tos;
    k = 0;
    @(negedge clk);
    while (inReady !== 1'b1)
    begin
      @(negedge clk);
      k++;
      if (k > 200) hang;
    end
    @(posedge clk);
    inValid <= 1'b0;
    nSent++;
  endtask
  task automatic getRes(input logic [RES_W-1:0] exp);
    int k;
    k = 0;
    while (gotCnt !== 16'(nSent))
    begin
      @(negedge clk);
      k++;
      if (k > 600) hang;
    end
    chk(lastRes, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, psel, penable, pwrite, inValid, inOffline, hold, slow} = 8'h80;
    {paddr, pwdata, inSet, inPort, inLookupKey, inTos, inHashFields} = '0;
    inLen = 16'h0040;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      wr(A_SETSEL, {29'h0, rows[i].set});
      wr(A_SETCFG, {8'h00, rows[i].msk, 2'b00, rows[i].sh, rows[i].sp, 5'h00});
      wr(A_SETBASE, {8'h00, rows[i].base});
      send(rows[i].set, rows[i].off, 16'h0000, rows[i].tos);
      getRes({1'b0, C_GREEN, 1'b1, rows[i].set, rows[i].sp, rows[i].base + (24'(rows[i].tos & rows[i].msk)
        << rows[i].sh)});
      $display("row %0d done", i);
    end
    rd(A_OFFL, 32'h0000_0001);
    // chained lookup: entry 2 hands its info to entry 3
    wr(A_SETSEL, 32'h0000_0005);
    wr(A_SETCFG, 32'h0000_0005);
    wr(A_SETBASE, 32'h0000_0777);
    wr(A_ENTSEL, 32'h0000_0002);
    wr(A_ENTKEY, 32'h00AB_1234);
    wr(A_ENTACT, 32'h0000_0007);
    wr(A_ENTSEL, 32'h0000_0003);
    wr(A_ENTKEY, 32'h0000_AB34);
    wr(A_ENTFQ, 32'h0000_5555);
    wr(A_ENTACT, 32'h0009_0000);
    send(3'd5, 1'b0, 16'h1234, 8'h00);
    getRes({1'b0, C_GREEN, hitRes});
    send(3'd5, 1'b0, 16'h9999, 8'h00);
    getRes({1'b0, C_GREEN, 4'hD, 5'd0, 24'h00_0777});
    $display("lookup done");
    // empty buckets after reset make the first policed frames red
    wr(A_PRFSEL, 32'h0000_0005);
    wr(A_RATES, 32'h0000_0000);
    wr(A_BURST, 32'h0000_0000);
    wr(A_PRFCFG, 32'h0000_0002);
    wr(A_ENTACT, 32'h0009_0540);
    send(3'd5, 1'b0, 16'h1234, 8'h00);
    getRes({1'b1, C_RED, hitRes});
    wr(A_PRFCFG, 32'h0000_0001);
    send(3'd5, 1'b0, 16'h1234, 8'h00);
    getRes({1'b0, C_RED, hitRes});
    wr(A_RATES, 32'h0100_0100);
    wr(A_BURST, 32'h0800_0800);
    repeat (200) @(posedge clk);
    send(3'd5, 1'b0, 16'h1234, 8'h00);
    getRes({1'b0, C_GREEN, hitRes});
    $display("police done");
    wr(12'h100, 32'hFFFF_FFFF);
    chk({35'h0, rerr}, 36'h1);
    rd(A_CTRL, CTRL_RST);
    // fill the result fifo while the queue manager stalls, then drain slowly
    hold <= 1'b1;
    inSet <= 3'd1;
    inPort <= 4'h9;
    inValid <= 1'b1;
    for (int j = 0; j < 120; j++)
    begin
      @(negedge clk);
      if (inReady === 1'b1) nSent++;
    end
    @(posedge clk);
    inValid <= 1'b0;
    apb(1'b0, A_STAT, '0);
    chk({35'h0, rdat[1]}, 36'h1);
    hold <= 1'b0;
    slow <= 1'b1;
    getRes({1'b0, C_GREEN, 4'h9, 5'd3, 24'h00_0100});
    rd(A_STAT, 32'h0000_0004);
    $display("fifo done");
    wr(A_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk({35'h0, inReady}, 36'h0);
    rst <= 1'b1;
    nSent = 0;
    repeat (5) @(posedge clk);
    chk({33'h0, inReady, outValid, pready}, 36'h0);
    rst <= 1'b0;
    rd(A_CTRL, CTRL_RST);
    rd(A_SETHMSK, 32'hFFFF_FFFF);
    rd(A_FRAMES, 32'h0000_0000);
    $display("reset done");
    endOfTest;
  end
endmodule
`default_nettype wire
